// ---- verilog/ost_top.sv ----
// Oscillator stabilisation timing and internal oscillator trim, APB slave
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module ost_top
  import ost_pkg::*;
#(
  parameter int CNT_W = OST_CNT_W
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [OST_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  main_osc_clk_in,
  input  wire logic                  stop_entry,
  input  wire logic                  stop_release,
  input  wire logic                  main_clock_source_status,
  output logic                       main_crystal_en,
  output logic                       external_clock_in_en,
  output logic      [OST_TRIM_W-1:0] trim_code,
  output logic                       cpu_hold,
  output logic                       irq
);

  // ****************************************
  // Declarations
  // ****************************************
  ost_apb_req_t          req;
  ost_osc_ctrl_t         moc_q;
  logic [OST_TRIM_W-1:0] trim_q;
  logic [OST_WSEL_W-1:0] wsel_q;
  logic [OST_IRQ_W-1:0]  irq_stat_q;
  logic [OST_IRQ_W-1:0]  irq_stat_d;
  logic [OST_IRQ_W-1:0]  irq_mask_q;
  logic [OST_IRQ_W-1:0]  irq_event;
  logic [OST_STAT_W-1:0] stab_status;
  logic                  stab_done;
  logic                  done_prev_q;
  logic                  osc_sync;
  logic                  osc_prev_q;
  logic                  started_q;
  logic                  hold_q;
  logic                  mcs_q;
  logic [31:0]           rd_mux;
  logic                  rd_hit;

  // ****************************************
  // APB request decode
  // ****************************************
  assign req.index   = paddr[OST_ADDR_W-1:2];
  assign req.aligned = (paddr[1:0] == 2'b00);
  assign req.write   = pwrite;
  assign req.wdata   = pwdata;
  assign req.strb    = pstrb;

  wire req_live  = psel && penable;
  wire req_first = req_live && !pready;
  wire req_done  = req_live && pready;

  wire hit_trim  = req.aligned && (req.index == OST_IDX_TRIM);
  wire hit_moc   = req.aligned && (req.index == OST_IDX_MOC);
  wire hit_stat  = req.aligned && (req.index == OST_IDX_STATUS);
  wire hit_wsel  = req.aligned && (req.index == OST_IDX_WSEL);
  wire hit_clk   = req.aligned && (req.index == OST_IDX_CLKSTAT);
  wire hit_istat = req.aligned && (req.index == OST_IDX_IRQ_STAT);
  wire hit_imask = req.aligned && (req.index == OST_IDX_IRQ_MASK);

  assign rd_hit = hit_trim || hit_moc || hit_stat || hit_wsel ||
                  hit_clk || hit_istat || hit_imask;

  // Unmapped or unaligned address answers with an error
  wire rd_err = req_first && !rd_hit;

  // Byte-lane 0 carries every register, writes need that lane
  wire byte0  = req.strb[0];
  wire wr_acc = req_done && req.write && byte0;

  wire wr_wsel  = wr_acc && hit_wsel;
  wire wr_trim  = wr_acc && hit_trim;
  wire wr_moc   = wr_acc && hit_moc;
  wire wr_istat = wr_acc && hit_istat;
  wire wr_imask = wr_acc && hit_imask;

  // ****************************************
  // Read data selection
  // ****************************************
  // upper bits zero
  assign rd_mux =
    hit_trim  ? {27'h000_0000, trim_q} :
    hit_moc   ? {24'h00_0000, moc_q.stop, 6'h00, moc_q.ext_mode} :
    hit_stat  ? {27'h000_0000, stab_status} :
    hit_wsel  ? {29'h0000_0000, wsel_q} :
    hit_clk   ? {30'h0000_0000, started_q, mcs_q} :
    hit_istat ? {30'h0000_0000, irq_stat_q} :
    hit_imask ? {30'h0000_0000, irq_mask_q} :
                32'h0000_0000;

  // ****************************************
  // APB answer, one wait state
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= req_first;
      pslverr <= rd_err;
      if (req_first) begin
        prdata  <= rd_mux;
      end
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  // status has no write path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_q     <= OST_TRIM_RST[OST_TRIM_W-1:0];
      wsel_q     <= OST_WSEL_RST[OST_WSEL_W-1:0];
      moc_q.stop <= OST_MOC_RST[OST_MOC_STOP_BIT];
      moc_q.ext_mode <= OST_MOC_RST[OST_MOC_EXT_BIT];
      irq_mask_q <= OST_IRQ_RST;
    end else begin
      if (wr_trim) begin
        trim_q <= req.wdata[OST_TRIM_W-1:0];
      end
      if (wr_wsel) begin
        wsel_q <= req.wdata[OST_WSEL_W-1:0];
      end
      if (wr_moc) begin
        moc_q.stop     <= req.wdata[OST_MOC_STOP_BIT];
        moc_q.ext_mode <= req.wdata[OST_MOC_EXT_BIT];
      end
      if (wr_imask) begin
        irq_mask_q <= req.wdata[OST_IRQ_W-1:0];
      end
    end
  end

  // ****************************************
  // Oscillator pin sampling
  // ****************************************
  // resonator or external clock
  ost_sync #(
    .W (1)
  ) u_osc_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (main_osc_clk_in),
    .dout  (osc_sync)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_sync;
    end
  end

  wire osc_edge = osc_sync && !osc_prev_q && !moc_q.stop;

  wire stab_clr = stop_entry || moc_q.stop;

  // ****************************************
  // Oscillation seen flag
  // ****************************************
  // first real edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started_q <= 1'b0;
    end else if (stab_clr) begin
      started_q <= 1'b0;
    end else if (osc_edge) begin
      started_q <= 1'b1;
    end
  end

  // ****************************************
  // Stabilisation counter
  // ****************************************
  // status limited by select
  ost_stab_counter #(
    .CNT_W (CNT_W)
  ) u_counter (
    .clk      (pclk),
    .rst_n    (presetn),
    .clr      (stab_clr),
    .tick     (osc_edge),
    .wsel     (wsel_q),
    .status_q (stab_status),
    .done_q   (stab_done)
  );

  // ****************************************
  // Processor clock source view
  // ****************************************
  // clock source sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcs_q <= 1'b0;
    end else begin
      mcs_q <= main_clock_source_status;
    end
  end

  // ****************************************
  // Processor hold after stop release
  // ****************************************
  // hold until wait elapsed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
    end else if (stop_release && mcs_q && !stab_done) begin
      hold_q <= 1'b1;
    end else if (stab_done) begin
      hold_q <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt status, write one to clear
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_prev_q <= 1'b0;
    end else begin
      done_prev_q <= stab_done;
    end
  end

  assign irq_event[OST_IRQ_START] = osc_edge && !started_q;
  assign irq_event[OST_IRQ_DONE]  = stab_done && !done_prev_q;

  // Set wins over a clear in the same cycle
  assign irq_stat_d = (irq_stat_q &
                      ~(wr_istat ? req.wdata[OST_IRQ_W-1:0] : '0)) |
                      irq_event;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= OST_IRQ_RST;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_crystal_en      <= 1'b0;
      external_clock_in_en <= 1'b0;
      trim_code            <= OST_TRIM_RST[OST_TRIM_W-1:0];
      cpu_hold             <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      main_crystal_en      <= !moc_q.stop && !moc_q.ext_mode;
      external_clock_in_en <= !moc_q.stop && moc_q.ext_mode;
      trim_code            <= trim_q;
      cpu_hold             <= hold_q;
      irq                  <= |(irq_stat_d & irq_mask_q);
    end
  end

endmodule : ost_top

// ---- verilog/ost_pkg.sv ----
// Constants, field layouts and carrier types of the oscillator stabilisation block
package ost_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int          OST_ADDR_W = 18;
  localparam int          OST_IDX_W  = 16;

  // Register indices, byte address is four times the index
  localparam logic [15:0] OST_IDX_TRIM     = 16'hff30;
  localparam logic [15:0] OST_IDX_MOC      = 16'hffa2;
  localparam logic [15:0] OST_IDX_STATUS   = 16'hffa3;
  localparam logic [15:0] OST_IDX_WSEL     = 16'hffa4;
  localparam logic [15:0] OST_IDX_CLKSTAT  = 16'hffa5;
  localparam logic [15:0] OST_IDX_IRQ_STAT = 16'hffa6;
  localparam logic [15:0] OST_IDX_IRQ_MASK = 16'hffa7;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0]  OST_TRIM_RST     = 8'h10;
  localparam logic [7:0]  OST_WSEL_RST     = 8'h05;
  localparam logic [7:0]  OST_MOC_RST      = 8'h80;
  localparam logic [7:0]  OST_STATUS_RST   = 8'h00;
  localparam logic [1:0]  OST_IRQ_RST      = 2'h0;
  localparam int          OST_MOC_STOP_BIT = 7;
  localparam int          OST_MOC_EXT_BIT  = 0;
  localparam int          OST_IRQ_START    = 0;
  localparam int          OST_IRQ_DONE     = 1;
  localparam int          OST_TRIM_W       = 5;
  localparam int          OST_WSEL_W       = 3;
  localparam int          OST_STAT_W       = 5;
  localparam int          OST_IRQ_W        = 2;

  // ****************************************
  // Stabilisation counts in main oscillator cycles
  // ****************************************
  localparam int          OST_CNT_W    = 17;
  localparam logic [16:0] OST_THR_2E11 = 17'h0_0800;
  localparam logic [16:0] OST_THR_2E13 = 17'h0_2000;
  localparam logic [16:0] OST_THR_2E14 = 17'h0_4000;
  localparam logic [16:0] OST_THR_2E15 = 17'h0_8000;
  localparam logic [16:0] OST_THR_2E16 = 17'h1_0000;

  // Wait select codes
  localparam logic [2:0]  OST_WSEL_2E11 = 3'h1;
  localparam logic [2:0]  OST_WSEL_2E13 = 3'h2;
  localparam logic [2:0]  OST_WSEL_2E14 = 3'h3;
  localparam logic [2:0]  OST_WSEL_2E15 = 3'h4;
  localparam logic [2:0]  OST_WSEL_2E16 = 3'h5;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [15:0] index;
    logic        aligned;
    logic        write;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } ost_apb_req_t;

  typedef struct packed {
    logic stop;
    logic ext_mode;
  } ost_osc_ctrl_t;

endpackage : ost_pkg

// ---- verilog/ost_sync.sv ----
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ost_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // ****************************************
  // Synchroniser chain
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : ost_sync

// ---- verilog/ost_stab_counter.sv ----
// Stabilisation counter with thermometer status
`timescale 1ns/1ps
module ost_stab_counter
  import ost_pkg::*;
#(
  parameter int CNT_W = OST_CNT_W
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  clr,
  input  wire logic                  tick,
  input  wire logic [OST_WSEL_W-1:0] wsel,
  output logic      [OST_STAT_W-1:0] status_q,
  output logic                       done_q
);

  logic [CNT_W-1:0]      cnt_q;
  logic [CNT_W-1:0]      cnt_d;
  logic [CNT_W-1:0]      limit;
  logic [OST_STAT_W-1:0] reach;
  logic [OST_STAT_W-1:0] status_d;
  wire                   at_limit = (cnt_q >= limit);

  // Limit per code, prohibited codes act as the longest wait
  // wait code decode
  assign limit = (wsel == OST_WSEL_2E11) ? CNT_W'(OST_THR_2E11) :
                 (wsel == OST_WSEL_2E13) ? CNT_W'(OST_THR_2E13) :
                 (wsel == OST_WSEL_2E14) ? CNT_W'(OST_THR_2E14) :
                 (wsel == OST_WSEL_2E15) ? CNT_W'(OST_THR_2E15) :
                                           CNT_W'(OST_THR_2E16);

  // ****************************************
  // Thermometer thresholds, bit 4 first
  // ****************************************
  localparam logic [16:0] THR [OST_STAT_W] = '{
    OST_THR_2E11, OST_THR_2E13, OST_THR_2E14, OST_THR_2E15, OST_THR_2E16};

  genvar gi;
  generate
    for (gi = 0; gi < OST_STAT_W; gi++) begin : g_thr
      assign reach[OST_STAT_W-1-gi] = (cnt_q >= CNT_W'(THR[gi]));
    end
  endgenerate

  assign cnt_d    = clr ? '0 :
                    (tick && !at_limit) ? cnt_q + 1'b1 : cnt_q;
  assign status_d = clr ? '0 : (status_q | reach);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= '0;
      status_q <= '0;
      done_q   <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      status_q <= status_d;
      done_q   <= !clr && at_limit;
    end
  end

endmodule : ost_stab_counter

// ---- tb/ost_osc_model.sv ----
// Behavioural main oscillator: resonator or external clock source
`timescale 1ns/1ps
module ost_osc_model #(
  parameter int HALF_NS  = 50,
  parameter int START_NS = 2000
) (
  input  wire logic en,
  output logic      osc
);
  initial osc = 1'b0;
  always begin
    wait (en);
    #(START_NS * 1ns);
    while (en) begin
      #(HALF_NS * 1ns);
      osc = ~osc;
    end
    osc = 1'b0;
  end
endmodule : ost_osc_model

// ---- tb/ost_top_checker.sv ----
// Concurrent checks on the stabilisation block ports
`timescale 1ns/1ps
module ost_top_checker
  import ost_pkg::*;
#(
  parameter int CNT_W = OST_CNT_W
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [OST_ADDR_W-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  stop_release,
  input wire logic                  main_crystal_en,
  input wire logic                  external_clock_in_en,
  input wire logic [OST_TRIM_W-1:0] trim_code,
  input wire logic                  cpu_hold,
  input wire logic                  irq
);
  localparam logic [17:0] A_TRIM = {OST_IDX_TRIM, 2'b00};
  localparam logic [17:0] A_STAT = {OST_IDX_STATUS, 2'b00};
  localparam logic [17:0] A_MASK = {OST_IDX_IRQ_MASK, 2'b00};
  wire acc = psel && penable && pready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready high for more than one cycle");
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_err_data: assert property (pslverr && !pwrite |-> pready && prdata == 0)
    else $error("error answer without ready or with data");
  a_status_upper: assert property (
    acc && !pwrite && paddr == A_STAT |-> prdata[31:5] == 27'h0)
    else $error("status upper bits not zero");
  a_trim_apply: assert property (
    acc && pwrite && paddr == A_TRIM && pstrb[0]
    |-> ##2 trim_code == $past(pwdata[4:0], 2))
    else $error("trim code does not follow write");
  a_osc_excl: assert property (
    !(main_crystal_en && external_clock_in_en))
    else $error("crystal and external clock both enabled");
  a_hold_cause: assert property (
    $rose(cpu_hold) |-> $past(stop_release, 2))
    else $error("hold without stop release");
  a_mask_quiet: assert property (acc && pwrite && paddr == A_MASK
    && pstrb[0] && pwdata[1:0] == 2'b00 |-> ##2 !irq)
    else $error("irq high with all masked");
endmodule : ost_top_checker

bind ost_top ost_top_checker #(.CNT_W(CNT_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stop_release(stop_release), .main_crystal_en(main_crystal_en),
  .external_clock_in_en(external_clock_in_en), .trim_code(trim_code),
  .cpu_hold(cpu_hold), .irq(irq));

// ---- tb/tb.sv ----
// Register level testbench of the stabilisation block
`timescale 1ns/1ps
module tb;
  import ost_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        stp_in = 1'b0, stp_out = 1'b0, src_hs = 1'b0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, rerr, osc, xen, een, hold, irq;
  logic [4:0]  trim_code;
  int          bad_count = 0;
  int          n_compared = 0;
  int          k;
  logic [31:0] tw [3] = '{32'h0000_00ff, 32'h0, 32'h0000_0010};
  logic [31:0] te [3] = '{32'h0000_001f, 32'h0, 32'h0000_0010};

  always #2.5 pclk = ~pclk;

  ost_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_osc_clk_in(osc), .stop_entry(stp_in), .stop_release(stp_out),
    .main_clock_source_status(src_hs), .main_crystal_en(xen),
    .external_clock_in_en(een), .trim_code(trim_code),
    .cpu_hold(hold), .irq(irq));
  ost_osc_model u_osc (.en(xen | een), .osc(osc));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [15:0] i, input logic [31:0] d,
           input logic [3:0] s);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {i, 2'b00};
    pwdata <= d;
    pstrb  <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rd(input logic [15:0] i, input logic [31:0] e, input logic er);
    apb(1'b0, i, 32'h0, 4'h0);
    chk(rdat, e);
    chk({31'h0, rerr}, {31'h0, er});
  endtask : rd

  task wr(input logic [15:0] i, input logic [31:0] d);
    apb(1'b1, i, d, 4'h1);
  endtask : wr

  task wait_irq;
    k = 0;
    while (irq !== 1'b1 && k < 45000) begin
      @(posedge pclk);
      k++;
    end
    chk({31'h0, irq}, 32'h1);
  endtask : wait_irq

  task tally_and_finish;
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (95000) @(posedge pclk);
    bad_count++;
    tally_and_finish;
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OST_IDX_TRIM, 32'h0000_0010, 1'b0);
    rd(OST_IDX_STATUS, 32'h0, 1'b0);
    rd(OST_IDX_WSEL, 32'h0000_0005, 1'b0);
    rd(OST_IDX_MOC, 32'h0000_0080, 1'b0);
    rd(16'h1234, 32'h0, 1'b1);
    chk({27'h0, trim_code}, 32'h0000_0010);
    apb(1'b1, OST_IDX_WSEL, 32'h0000_0003, 4'h0);
    rd(OST_IDX_WSEL, 32'h0000_0005, 1'b0);
    wr(OST_IDX_STATUS, 32'h0000_001f);
    rd(OST_IDX_STATUS, 32'h0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(OST_IDX_TRIM, tw[i]);
      rd(OST_IDX_TRIM, te[i], 1'b0);
      chk({27'h0, trim_code}, te[i]);
    end
    wr(OST_IDX_WSEL, 32'h0000_0001);
    wr(OST_IDX_IRQ_MASK, 32'h0000_0002);
    wr(OST_IDX_MOC, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, xen}, 32'h1);
    rd(OST_IDX_CLKSTAT, 32'h0, 1'b0);
    stp_out <= 1'b1;
    @(posedge pclk);
    stp_out <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, hold}, 32'h0);
    wait_irq();
    rd(OST_IDX_STATUS, 32'h0000_0010, 1'b0);
    repeat (1000) @(posedge pclk);
    rd(OST_IDX_STATUS, 32'h0000_0010, 1'b0);
    rd(OST_IDX_IRQ_STAT, 32'h0000_0003, 1'b0);
    wr(OST_IDX_IRQ_STAT, 32'h0000_0003);
    rd(OST_IDX_IRQ_STAT, 32'h0, 1'b0);
    chk({31'h0, irq}, 32'h0);
    src_hs <= 1'b1;
    stp_in <= 1'b1;
    @(posedge pclk);
    stp_in <= 1'b0;
    rd(OST_IDX_STATUS, 32'h0, 1'b0);
    stp_out <= 1'b1;
    @(posedge pclk);
    stp_out <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, hold}, 32'h1);
    wait_irq();
    repeat (3) @(posedge pclk);
    chk({31'h0, hold}, 32'h0);
    rd(OST_IDX_STATUS, 32'h0000_0010, 1'b0);
    rd(OST_IDX_CLKSTAT, 32'h0000_0003, 1'b0);
    wr(OST_IDX_MOC, 32'h0000_0080);
    repeat (2) @(posedge pclk);
    chk({31'h0, xen}, 32'h0);
    rd(OST_IDX_STATUS, 32'h0, 1'b0);
    wr(OST_IDX_MOC, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({31'h0, een}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(OST_IDX_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    tally_and_finish;
  end
endmodule : tb
